// [core/pit_pkg.sv]
package pit_pkg;

  typedef enum logic [1:0] {
    TS_SEC = 2'b00,
    TS_MIN = 2'b01,
    TS_HR  = 2'b10
  } ts_sel_t;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_RAW  = 3'b001,
    DS_DIV  = 3'b010,
    DS_POST = 3'b011
  } div_state_t;

  typedef struct packed {
    logic [15:0] unit_scale_factor;
    logic [15:0] meter_factor;
  } chan_scale_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic [2:0] filt_shift;
    ts_sel_t time_scale_select;
    logic [15:0] chg_limit;
  } chan_chg_t;

endpackage

// [core/pit_regs.svh]
`ifndef PIT_REGS_SVH
`define PIT_REGS_SVH

// Timing
`define PIT_NCH 8
`define PIT_HW_BITS 16
`define PIT_CLK_HZ 40000000
`define PIT_TICK_MS 20
`define PIT_TICK_CYC ((`PIT_CLK_HZ / 1000) * `PIT_TICK_MS)
`define PIT_TICKS_PER_S (1000 / `PIT_TICK_MS)
`define PIT_HS_MS 500
`define PIT_HS_TICKS (`PIT_HS_MS / `PIT_TICK_MS)
`define PIT_CHG_MS 4000
`define PIT_CHG_HS (`PIT_CHG_MS / `PIT_HS_MS)
`define PIT_MAX_HZ 20000
`define PIT_MAX_PER_TICK ((`PIT_MAX_HZ * `PIT_TICK_MS) / 1000)

// Time scale multipliers
`define PIT_TS_MUL_SEC 12'h001
`define PIT_TS_MUL_MIN 12'h03C
`define PIT_TS_MUL_HR 12'hE10

// Register byte offsets
`define PIT_CTRL 12'h000
`define PIT_INT_STATUS 12'h004
`define PIT_INT_CLEAR 12'h008
`define PIT_INT_ENABLE 12'h00C
`define PIT_TOTAL_STATUS 12'h010
`define PIT_TICK_COUNT 12'h014
`define PIT_CFG_PAGE 4'h1
`define PIT_RES_PAGE 4'h2

// Field positions
`define PIT_CTRL_RUN 0
`define PIT_CTRL_ACT_LSB 8
`define PIT_EVT_ERR_LSB 0
`define PIT_EVT_HI_LSB 8
`define PIT_EVT_LO_LSB 16
`define PIT_EVT_CHG_LSB 24

// Reset values
`define PIT_SCALE_RST 32'h0001_0001
`define PIT_HI_RST 32'hFFFF_FFFF
`define PIT_LO_RST 32'h0000_0000
`define PIT_ROCCFG_RST 32'h0000_FFFF

`endif

// [core/pulse_channel.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pit_regs.svh"

module pulse_channel #(
  parameter int HW = `PIT_HW_BITS
) (
  input wire logic pclk, // Module clock
  input wire logic presetn, // Async reset, low
  input wire logic pulse_in, // Field pulse
  input wire logic clear, // Zero the total
  input wire logic sample, // 20 ms sample strobe
  output logic [31:0] total_q, // Extended total
  output logic [HW-1:0] tick_delta_q // Pulses in last window
);

  logic s1_q, s2_q, s3_q;
  logic rise;
  logic [HW-1:0] cnt_q, cnt_nx, last_q, step;

  // Two-flop synchroniser, third stage for the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pulse_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q & ~s3_q; // RL15
  assign cnt_nx = cnt_q + HW'(rise);
  // Window count kept at counter width so a counter wrap stays exact
  assign step = cnt_nx - last_q;

  // Hardware counter, one count per rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_nx; // RL15
    end
  end

  // Total extended from the counter; rolls freely, no user reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_q <= '0;
      last_q <= '0;
      tick_delta_q <= '0;
    end else if (clear) begin
      total_q <= '0; // RL7
      last_q <= '0;
      tick_delta_q <= '0;
    end else if (sample) begin
      total_q <= total_q + 32'(step); // RL4 RL5 RL6
      last_q <= cnt_nx;
      tick_delta_q <= step;
    end
  end

  // Assertions share the module clock and reset
  default clocking chk_clk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_LOW_BITS: assert property (sample && !clear |=> // RL5
    total_q[HW-1:0] == $past(cnt_nx))
    else $error("total low bits differ from counter");

  AST_CLEAR_ZERO: assert property (clear |=> // RL7
    total_q == 32'h0000_0000 && cnt_q == '0)
    else $error("total not zero after clear");

  AST_HOLD: assert property (!sample && !clear |=> $stable(total_q)) // RL4
    else $error("total changed between samples");

endmodule

`default_nettype wire

// [core/pulse_input_totalizer.sv]
// Notes on behaviour
// [RL1] Eight independent counting channels
// [RL2] Counts correctly up to 20 kHz
// [RL3] Totalizing and rate always run together
// [RL4] 32-bit total refreshed every 20 ms
// [RL5] Low total bits from hardware counter
// [RL6] Total wraps freely, no start/stop/reset
// [RL7] Total zeroed only inactive, idle, error
// [RL8] Error zeroing marks total status bad
// [RL9] Raw rate is delta over elapsed seconds
// [RL10] Rate valid above 0.4 Hz only
// [RL11] Scaled rate from unit, time, meter factors
// [RL12] Time scale per second, minute, hour
// [RL13] Alarms half second, rate change four seconds
// [RL14] Half-second unsigned total delta for display
// [RL15] Synchronised input, one count per edge
// [RL16] Elapsed time from free-running time_scale_select
`timescale 1ns/10ps
`default_nettype none
`include "pit_regs.svh"

module pulse_input_totalizer
  import pit_pkg::*;
#(
  parameter int TICK_CYC = `PIT_TICK_CYC
) (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error
  input wire logic [`PIT_NCH-1:0] pulse_in, // Meter pulses
  output logic irq // Level interrupt
);

  localparam int NCH = `PIT_NCH;
  localparam int HW = `PIT_HW_BITS;

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;
  logic run_q;
  logic [NCH-1:0] act_q, err_q, bad_q, clr_ch;
  logic [NCH-1:0] hi_lvl_q, lo_lvl_q, chg_lvl_q;
  logic [31:0] int_sts_q, int_en_q, int_set;
  chan_scale_t scale_q [NCH];
  chan_chg_t rocc_q [NCH];
  logic [31:0] hi_q [NCH];
  logic [31:0] lo_q [NCH];
  logic [31:0] total [NCH];
  logic [HW-1:0] tick_delta [NCH];
  logic [31:0] last_hs_q [NCH];
  logic [31:0] delta_hs_q [NCH];
  logic [31:0] raw_q [NCH];
  logic [31:0] scaled_q [NCH];
  logic [31:0] filt_q [NCH];
  logic [31:0] chg_ref_q [NCH];
  logic [31:0] tick_cnt_q, tb_q, tb_hs_q, elapsed_q;
  logic [4:0] hs_cnt_q;
  logic [2:0] chg_cnt_q;
  logic tick20, tick_d1_q, hs_tick_q, chg_pass_q;
  div_state_t div_state_q;
  logic [2:0] div_ch_q;
  logic div_phase_q;
  logic [63:0] num_q, quo_q;
  logic [31:0] den_q;
  logic [32:0] rem_q, rem_sh;
  logic [5:0] div_cnt_q;
  logic [31:0] sat, filt_new, chg_diff;
  logic [32:0] fdiff;
  logic hi_new, lo_new, chg_new, post_fin;
  logic wr_en, rd_err;
  logic [31:0] rd_data;
  logic [2:0] rch;

  // Multiplier for the selected time scale
  function automatic logic [11:0] ts_mul(input ts_sel_t sel);
    case (sel)
      TS_MIN: ts_mul = `PIT_TS_MUL_MIN; // RL12
      TS_HR: ts_mul = `PIT_TS_MUL_HR; // RL12
      default: ts_mul = `PIT_TS_MUL_SEC;
    endcase
  endfunction

  // Zero divisors become one so a zero divisor gives the dividend rather than an all-ones quotient
  function automatic logic [31:0] nz(input logic [31:0] v);
    nz = (v == 32'h0000_0000) ? 32'h0000_0001 : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Channels

  // Inactive or idle channels hold their total at zero; a fault zeroes it for one cycle
  assign clr_ch = ~act_q | {NCH{~run_q}} | err_q; // RL7

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    pulse_channel #(.HW(HW)) u_ch ( // RL1 RL3
      .pclk(pclk),
      .presetn(presetn),
      .pulse_in(pulse_in[g]),
      .clear(clr_ch[g]),
      .sample(tick20),
      .total_q(total[g]),
      .tick_delta_q(tick_delta[g])
    );
  end

  // More pulses in a window than 20 kHz allows is a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= '0;
      bad_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        err_q[i] <= tick_d1_q && !clr_ch[i] &&
          (32'(tick_delta[i]) > 32'(`PIT_MAX_PER_TICK)); // RL2
        if (err_q[i]) begin
          bad_q[i] <= 1'b1; // RL8
        end else if (!act_q[i]) begin
          bad_q[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time_scale_select: 20 ms tick, half second, four seconds

  assign tick20 = (tick_cnt_q == 32'(TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      tb_q <= '0;
      hs_cnt_q <= '0;
      tick_d1_q <= 1'b0;
      hs_tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick20 ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      tick_d1_q <= tick20;
      hs_tick_q <= tick20 && (hs_cnt_q == 5'(`PIT_HS_TICKS - 1));
      if (tick20) begin
        tb_q <= tb_q + 32'h0000_0001; // RL16
        hs_cnt_q <= (hs_cnt_q == 5'(`PIT_HS_TICKS - 1)) ? 5'h00 :
          hs_cnt_q + 5'h01;
      end
    end
  end

  // Half-second snapshot; rate of change only every eighth pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_hs_q <= '0;
      elapsed_q <= '0;
      chg_cnt_q <= '0;
      chg_pass_q <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        last_hs_q[i] <= '0;
        delta_hs_q[i] <= '0;
      end
    end else if (hs_tick_q) begin
      tb_hs_q <= tb_q;
      elapsed_q <= tb_q - tb_hs_q; // RL16
      chg_cnt_q <= chg_cnt_q + 3'h1;
      chg_pass_q <= (chg_cnt_q == 3'(`PIT_CHG_HS - 1)); // RL13
      for (int i = 0; i < NCH; i++) begin
        delta_hs_q[i] <= total[i] - last_hs_q[i]; // RL14
        last_hs_q[i] <= total[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared serial divider: raw rate, then scaled rate, per channel

  // Slow but tiny: 64 cycles per divide, 16 divides per half second
  assign rem_sh = {rem_q[31:0], num_q[63]};
  assign sat = (|quo_q[63:32]) ? 32'hFFFF_FFFF : quo_q[31:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_state_q <= DS_IDLE;
      div_ch_q <= '0;
      div_phase_q <= 1'b0;
      num_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      quo_q <= '0;
      div_cnt_q <= '0;
    end else begin
      case (div_state_q)
        DS_IDLE: begin
          div_ch_q <= '0;
          if (hs_tick_q) begin
            div_state_q <= DS_RAW;
          end
        end
        DS_RAW: begin
          // Pulses per second from ticks of the time_scale_select
          num_q <= 64'(delta_hs_q[div_ch_q]) *
            64'(`PIT_TICKS_PER_S); // RL9
          den_q <= nz(elapsed_q); // RL9
          rem_q <= '0;
          div_cnt_q <= '0;
          div_phase_q <= 1'b0;
          div_state_q <= DS_DIV;
        end
        DS_DIV: begin
          num_q <= {num_q[62:0], 1'b0};
          if (rem_sh >= {1'b0, den_q}) begin
            rem_q <= rem_sh - {1'b0, den_q};
            quo_q <= {quo_q[62:0], 1'b1};
          end else begin
            rem_q <= rem_sh;
            quo_q <= {quo_q[62:0], 1'b0};
          end
          div_cnt_q <= div_cnt_q + 6'h01;
          if (div_cnt_q == 6'h3F) begin
            div_state_q <= DS_POST;
          end
        end
        DS_POST: begin
          if (!div_phase_q) begin
            num_q <= 64'(sat) *
              64'(scale_q[div_ch_q].unit_scale_factor) *
              64'(ts_mul(rocc_q[div_ch_q].time_scale_select)); // RL11
            den_q <= nz(32'(scale_q[div_ch_q].meter_factor)); // RL11
            rem_q <= '0;
            div_cnt_q <= '0;
            div_phase_q <= 1'b1;
            div_state_q <= DS_DIV;
          end else if (div_ch_q == 3'(NCH - 1)) begin
            div_state_q <= DS_IDLE;
          end else begin
            div_ch_q <= div_ch_q + 3'h1;
            div_state_q <= DS_RAW;
          end
        end
        default: div_state_q <= DS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Filter and alarms on the scaled rate

  assign post_fin = (div_state_q == DS_POST) && div_phase_q;

  // First-order lag; a shift of zero passes the rate straight through
  always_comb begin
    fdiff = {1'b0, sat} - {1'b0, filt_q[div_ch_q]};
    filt_new = filt_q[div_ch_q] +
      32'($signed(fdiff) >>> rocc_q[div_ch_q].filt_shift);
    chg_diff = (filt_new >= chg_ref_q[div_ch_q]) ?
      filt_new - chg_ref_q[div_ch_q] : chg_ref_q[div_ch_q] - filt_new;
    hi_new = filt_new > hi_q[div_ch_q]; // RL13
    lo_new = filt_new < lo_q[div_ch_q]; // RL13
    chg_new = chg_diff > {16'h0000, rocc_q[div_ch_q].chg_limit};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_lvl_q <= '0;
      lo_lvl_q <= '0;
      chg_lvl_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        raw_q[i] <= '0;
        scaled_q[i] <= '0;
        filt_q[i] <= '0;
        chg_ref_q[i] <= '0;
      end
    end else if (div_state_q == DS_POST) begin
      if (!div_phase_q) begin
        raw_q[div_ch_q] <= sat; // RL9 RL10
      end else begin
        scaled_q[div_ch_q] <= sat; // RL11
        filt_q[div_ch_q] <= filt_new;
        hi_lvl_q[div_ch_q] <= hi_new;
        lo_lvl_q[div_ch_q] <= lo_new;
        if (chg_pass_q) begin
          chg_lvl_q[div_ch_q] <= chg_new; // RL13
          chg_ref_q[div_ch_q] <= filt_new;
        end
      end
    end
  end

  // High, low and change events fire on entry into an alarm, not while it persists; error events fire on every faulted window
  always_comb begin
    int_set = '0;
    int_set[`PIT_EVT_ERR_LSB +: NCH] = err_q; // RL8
    if (post_fin) begin
      int_set[`PIT_EVT_HI_LSB + 32'(div_ch_q)] = hi_new &
        ~hi_lvl_q[div_ch_q];
      int_set[`PIT_EVT_LO_LSB + 32'(div_ch_q)] = lo_new &
        ~lo_lvl_q[div_ch_q];
      int_set[`PIT_EVT_CHG_LSB + 32'(div_ch_q)] = chg_pass_q &
        chg_new & ~chg_lvl_q[div_ch_q]; // RL13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, read data captured in setup

  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
  assign rch = paddr[6:4];

  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (paddr[11:8] == `PIT_CFG_PAGE && !paddr[7]) begin
      case (paddr[3:2])
        2'h0: rd_data = scale_q[rch];
        2'h1: rd_data = hi_q[rch];
        2'h2: rd_data = lo_q[rch];
        default: rd_data = rocc_q[rch];
      endcase
    end else if (paddr[11:8] == `PIT_RES_PAGE && !paddr[7]) begin
      case (paddr[3:2])
        2'h0: rd_data = total[rch];
        2'h1: rd_data = raw_q[rch];
        2'h2: rd_data = scaled_q[rch];
        default: rd_data = delta_hs_q[rch];
      endcase
    end else begin
      case (paddr)
        `PIT_CTRL: rd_data = {16'h0000, act_q, 7'h00, run_q};
        `PIT_INT_STATUS: rd_data = int_sts_q;
        `PIT_INT_CLEAR: rd_data = '0;
        `PIT_INT_ENABLE: rd_data = int_en_q;
        `PIT_TOTAL_STATUS: rd_data = {chg_lvl_q, lo_lvl_q, hi_lvl_q, bad_q};
        `PIT_TICK_COUNT: rd_data = tb_q;
        default: rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel && !penable;
      if (psel && !penable) begin
        pslverr_q <= rd_err;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      act_q <= '0;
      int_en_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        scale_q[i] <= `PIT_SCALE_RST;
        hi_q[i] <= `PIT_HI_RST;
        lo_q[i] <= `PIT_LO_RST;
        rocc_q[i] <= `PIT_ROCCFG_RST;
      end
    end else if (wr_en) begin
      if (paddr[11:8] == `PIT_CFG_PAGE) begin
        case (paddr[3:2])
          2'h0: scale_q[rch] <= pwdata;
          2'h1: hi_q[rch] <= pwdata;
          2'h2: lo_q[rch] <= pwdata;
          default: rocc_q[rch] <= {11'h000, pwdata[20:0]};
        endcase
      end else if (paddr == `PIT_CTRL) begin
        run_q <= pwdata[`PIT_CTRL_RUN];
        act_q <= pwdata[`PIT_CTRL_ACT_LSB +: NCH];
      end else if (paddr == `PIT_INT_ENABLE) begin
        int_en_q <= pwdata;
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sts_q <= '0;
      irq_q <= 1'b0;
    end else begin
      int_sts_q <= (int_sts_q &
        ~((wr_en && paddr == `PIT_INT_CLEAR) ? pwdata : 32'h0000_0000))
        | int_set;
      irq_q <= |(int_sts_q & int_en_q);
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // All checks run on the bus clock and sleep through reset
  default clocking chk_clk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_hs_start;
    hs_tick_q ##1 (div_state_q == DS_RAW);
  endsequence

  AST_IDLE_ZERO: assert property (!run_q |=> // RL7
    total[0] == 32'h0000_0000)
    else $error("total not zero while idle");

  AST_ERR_BAD: assert property (err_q[0] |=> // RL8
    bad_q[0] && total[0] == 32'h0000_0000)
    else $error("error did not mark total bad");

  AST_DELTA: assert property (hs_tick_q |=> // RL14
    delta_hs_q[0] == $past(total[0]) - $past(last_hs_q[0]))
    else $error("half-second delta wrong");

  AST_TB_STEP: assert property (tick20 |=> // RL16
    tb_q == $past(tb_q) + 32'h0000_0001)
    else $error("time_scale_select did not advance");

  AST_DIV_RUN: assert property (s_hs_start |=> // RL9
    (div_state_q == DS_DIV) [*8])
    else $error("divider did not start on half second");

  AST_HS_ON_TICK: assert property (hs_tick_q |-> $past(tick20)) // RL13
    else $error("half second not on a 20 ms tick");

  AST_CHG_GATE: assert property (int_set[`PIT_EVT_CHG_LSB] |-> // RL13
    chg_pass_q && post_fin)
    else $error("rate-of-change event outside four-second pass");

  AST_IRQ: assert property (|(int_sts_q & int_en_q) |=> irq_q)
    else $error("interrupt missing for enabled status");

  AST_TICK_LEN: assert property (tick20 |=> // RL4
    tick_cnt_q == 32'h0000_0000 && !tick20)
    else $error("20 ms counter did not restart");

endmodule

`default_nettype wire

// [sim/pulse_meter.sv]
`timescale 1ns/10ps
`default_nettype none

module pulse_meter (
  input wire logic pclk, // Sample clock
  input wire logic presetn, // Async reset, low
  input wire logic en, // Allow new pulses
  input wire logic [7:0][15:0] half_cyc, // Half period per channel
  output logic [7:0] pulse, // Meter outputs
  output logic [7:0][31:0] sent // Rising edges emitted
);
  logic [7:0][15:0] cnt_q;

  // Square wave per channel; a started pulse always completes, so a
  // stop never leaves a runt that the input flops could miss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse <= 8'h00;
      cnt_q <= '0;
      sent <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (cnt_q[i] != 16'h0000) begin
          cnt_q[i] <= cnt_q[i] - 16'h0001;
        end else if (pulse[i] || en) begin
          pulse[i] <= ~pulse[i];
          // Callers keep half periods >= 1000 cycles: 20 kHz at most
          cnt_q[i] <= half_cyc[i] - 16'h0001;
          if (!pulse[i]) begin
            sent[i] <= sent[i] + 32'h0000_0001;
          end
        end
      end
    end
  end
endmodule

`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pit_regs.svh"

module testbench import pit_pkg::*; ();
  localparam int TICK = 200;
  localparam int HS = TICK * `PIT_HS_TICKS;
  localparam logic [15:0] UNIT [8] = '{16'h0003, 16'h0001, 16'h0002,
    16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
  localparam logic [15:0] MTR [8] = '{16'h0002, 16'h0E10, 16'h0001,
    16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
  localparam logic [1:0] TS [8] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h0, 2'h0,
    2'h0, 2'h0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic meter_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, t0;
  logic [31:0] base [8];
  logic [7:0] pulse_in;
  logic [7:0][15:0] half_cyc;
  logic [7:0][31:0] sent;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int raw, sc, tm;

  pulse_input_totalizer #(.TICK_CYC(TICK)) pulse_input_totalizer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pulse_in(pulse_in), .irq(irq));

  pulse_meter pulse_meter_inst (.pclk(pclk), .presetn(presetn),
    .en(meter_en), .half_cyc(half_cyc), .pulse(pulse_in), .sent(sent));

  ////////////////////////////////////////////////////////////////////////
  // Free clock, 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Hang guard, about twice the expected run length
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    meter_en = 1'b1;
    for (int i = 0; i < 8; i++) begin
      half_cyc[i] = i[0] ? 16'h09C4 : 16'h04E2;
    end
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`PIT_CTRL, 32'h0000_0000);
    rchk(12'h100, `PIT_SCALE_RST);
    rchk(12'h174, `PIT_HI_RST);
    rchk(12'h128, `PIT_LO_RST);
    rchk(12'h13C, `PIT_ROCCFG_RST);
    rchk(`PIT_INT_ENABLE, 32'h0000_0000);
    apb(1'b0, 12'h300, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    // Idle module holds totals at zero while pulses arrive
    repeat (600) @(posedge pclk);
    rchk(12'h200, 32'h0000_0000);
    meter_en <= 1'b0;
    repeat (2600) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      base[i] = sent[i];
      apb(1'b1, {`PIT_CFG_PAGE, 4'(i), 4'h0},
          chan_scale_t'({UNIT[i], MTR[i]}));
      apb(1'b1, {`PIT_CFG_PAGE, 4'(i), 4'hC},
          chan_chg_t'({11'h000, 3'h0, TS[i], 16'hFFFF}));
    end
    apb(1'b1, 12'h134, 32'h0000_0001);
    apb(1'b1, 12'h148, 32'h0000_FFFF);
    // Channel 7 left inactive
    apb(1'b1, `PIT_CTRL, 32'h0000_7F01);
    meter_en <= 1'b1;
    repeat (4 * HS) @(posedge pclk);
    apb(1'b0, `PIT_TICK_COUNT, 32'h0000_0000);
    t0 = rd;
    repeat (2 * TICK - 3) @(posedge pclk);
    apb(1'b0, `PIT_TICK_COUNT, 32'h0000_0000);
    chk(rd - t0, 32'h0000_0002);
    for (int i = 0; i < 7; i++) begin
      raw = HS / (2 * int'(half_cyc[i]));
      rchk({`PIT_RES_PAGE, 4'(i), 4'hC}, 32'(raw));
      raw = raw * `PIT_TICKS_PER_S / `PIT_HS_TICKS;
      rchk({`PIT_RES_PAGE, 4'(i), 4'h4}, 32'(raw));
      tm = TS[i] == 2'h1 ? 60 : (TS[i] == 2'h2 ? 3600 : 1);
      sc = raw * int'(UNIT[i]) * tm / (MTR[i] == 16'h0 ? 1 : int'(MTR[i]));
      rchk({`PIT_RES_PAGE, 4'(i), 4'h8}, 32'(sc));
    end
    // High entry on channel 3, low entry on channel 4, still masked
    rchk(`PIT_INT_STATUS, 32'h0010_0800);
    // Alarm levels match the entries; no channel marked bad
    rchk(`PIT_TOTAL_STATUS, 32'h0010_0800);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `PIT_INT_ENABLE, 32'h0000_0800);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `PIT_INT_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `PIT_INT_ENABLE, 32'h0010_0800);
    apb(1'b1, `PIT_INT_CLEAR, 32'h0010_0800);
    rchk(`PIT_INT_STATUS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    rchk(`PIT_INT_CLEAR, 32'h0000_0000);
    // Stop the meters, let the last counts reach the totals
    meter_en <= 1'b0;
    repeat (2600 + 3 * TICK) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      t0 = (i == 7) ? 32'h0000_0000 : sent[i] - base[i];
      rchk({`PIT_RES_PAGE, 4'(i), 4'h0}, t0);
    end
    finish_test();
  end
endmodule

`default_nettype wire
